/* hdl/fsq_params.svh */
`ifndef FSQ_PARAMS_SVH
`define FSQ_PARAMS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define FSQ_CMD_RD_WORD 3'h0
`define FSQ_CMD_RD_INC 3'h1
`define FSQ_CMD_RD_PAGE 3'h2
`define FSQ_CMD_WR_WORD 3'h3
`define FSQ_CMD_WR_INC 3'h4
`define FSQ_CMD_WR_PAGE 3'h5
`define FSQ_CMD_ER_PAGE 3'h6
`define FSQ_CMD_RSVD 3'h7

// ----------------------------------------
// unlock keys
// ----------------------------------------
`define FSQ_KEY_FIRST 8'h55
`define FSQ_KEY_SECOND 8'hAA

// ----------------------------------------
// geometry
// ----------------------------------------
`define FSQ_PAGE_WORDS 128
`define FSQ_ADDR_W 22
`define FSQ_DATA_W 16
`define FSQ_IDX_W 7
`define FSQ_PAGE_LSB 8
`define FSQ_BYTE_PAD 1'h0
`define FSQ_IDX_LAST 7'h7F
`define FSQ_IDX_STEP 7'h01
`define FSQ_ADDR_STEP 22'h00_0002
`define FSQ_FLASH_BYTES 65536

// ----------------------------------------
// timing and phases
// ----------------------------------------
`define FSQ_PROG_TIME_NS 2000
`define FSQ_CLK_PERIOD_PS 5000
`define FSQ_PS_PER_NS 1000
`define FSQ_TMR_W 16
`define FSQ_TMR_ZERO 16'h0000
`define FSQ_TMR_STEP 16'h0001
`define FSQ_PH_ISSUE 2'h0
`define FSQ_PH_HOLD 2'h1
`define FSQ_PH_TAKE 2'h2
`define FSQ_PH_STEP 2'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define FSQ_RST_ADDR 22'h00_0000
`define FSQ_RST_DATA 16'h0000
`define FSQ_RST_IDX 7'h00

`endif

/* hdl/fsq_pkg.sv */
`include "fsq_params.svh"

package fsq_pkg;
   typedef enum logic [2:0] {
      FSQ_ST_IDLE = 3'h0,
      FSQ_ST_RD_WORD = 3'h1,
      FSQ_ST_RD_PAGE = 3'h2,
      FSQ_ST_WR_WORD = 3'h3,
      FSQ_ST_WR_PAGE = 3'h4,
      FSQ_ST_ERASE = 3'h5,
      FSQ_ST_PROG = 3'h6
   } fsq_state_t;

   typedef enum logic [1:0] {
      FSQ_LOCK_NONE = 2'h0,
      FSQ_LOCK_FIRST = 2'h1,
      FSQ_LOCK_ARMED = 2'h2
   } fsq_lock_t;
endpackage

/* hdl/fsq_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface fsq_buf_if #(parameter int AW = 7, parameter int DW = 16);
   logic en;
   logic we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output en, output we, output addr, output wdata, input rdata);
   modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

/* hdl/fsq_buf_ram.sv */
`timescale 1ns/1ps
`default_nettype none

module fsq_buf_ram #(parameter int AW = 7, parameter int DW = 16) (
   input wire logic clock_in,
   input wire logic rst_in,
   fsq_buf_if.mem port
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   // ----------------------------------------
   // storage and registered read
   // ----------------------------------------
   always_ff @(posedge clock_in) begin
      if (port.en && port.we) begin
         mem_q[port.addr] <= port.wdata;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= '0;
      end else if (port.en) begin
         rdata_q <= mem_q[port.addr];
      end
   end

   assign port.rdata = rdata_q;
endmodule

`default_nettype wire

/* hdl/fsq_sequencer.sv */
// Contract
// [RULE_01] unexpected reset mid write sets write error
// [RULE_02] write to protected area sets error
// [RULE_03] write to invalid address sets error
// [RULE_04] page read copies page to buffer
// [RULE_05] word read loads data register
// [RULE_06] software polls go or done flag
// [RULE_07] page write programs whole buffer to page
// [RULE_08] bad page write: go clears, flash untouched
// [RULE_09] cpu halted during write cycles
// [RULE_10] completion clears go, sets done, gated irq
// [RULE_11] buffer and command frozen during write
// [RULE_12] internal timer sets programming time
// [RULE_13] software pads buffer with erased values
// [RULE_14] page is 128 words, one buffer bank
// [RULE_15] buffer index maps onto page offset
// [RULE_16] software erases page before page write
// [RULE_17] software masks interrupts around unlock
// [RULE_18] word write only onto erased words
// [RULE_19] word write programs data register word
// [RULE_20] write needs 55 then AA then go
// [RULE_21] registers locked and go unclearable while busy
// [RULE_22] reserved command does nothing silently
// [RULE_23] go ignored unless keys directly precede
`timescale 1ns/1ps
`default_nettype none
`include "fsq_params.svh"

module fsq_sequencer #(
   parameter int FLASH_BYTES = `FSQ_FLASH_BYTES,
   parameter int PROG_CYC = (`FSQ_PROG_TIME_NS * `FSQ_PS_PER_NS + `FSQ_CLK_PERIOD_PS - 1)
      / `FSQ_CLK_PERIOD_PS
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic cmd_wr_in,
   input wire logic [2:0] cmd_in,
   input wire logic addr_wr_in,
   input wire logic [`FSQ_ADDR_W-1:0] addr_in,
   input wire logic data_wr_in,
   input wire logic [`FSQ_DATA_W-1:0] data_in,
   input wire logic lock_wr_in,
   input wire logic [7:0] lock_in,
   input wire logic go_set_in,
   input wire logic irq_en_in,
   input wire logic done_clr_in,
   input wire logic err_clr_in,
   input wire logic protect_in,
   input wire logic fault_rst_in,
   input wire logic buf_wr_in,
   input wire logic [`FSQ_IDX_W-1:0] buf_addr_in,
   input wire logic [`FSQ_DATA_W-1:0] buf_wdata_in,
   output logic [`FSQ_DATA_W-1:0] buf_rdata_out,
   input wire logic [`FSQ_DATA_W-1:0] fl_rdata_in,
   output logic [`FSQ_ADDR_W-1:0] fl_addr_out,
   output logic fl_rd_out,
   output logic fl_wr_out,
   output logic fl_erase_out,
   output logic [`FSQ_DATA_W-1:0] fl_wdata_out,
   output logic go_out,
   output logic [2:0] cmd_out,
   output logic [`FSQ_ADDR_W-1:0] addr_out,
   output logic [`FSQ_DATA_W-1:0] data_out,
   output logic err_out,
   output logic done_out,
   output logic irq_out,
   output logic cpu_halt_out
);
   fsq_pkg::fsq_state_t state_q;
   fsq_pkg::fsq_lock_t lock_q;
   logic go_q, err_q, done_q, done_d, irq_q, halt_q;
   logic [2:0] cmd_q;
   logic [`FSQ_ADDR_W-1:0] addr_q, fl_addr_q;
   logic [`FSQ_DATA_W-1:0] data_q, fl_wdata_q;
   logic fl_rd_q, fl_wr_q, fl_er_q;
   logic [`FSQ_IDX_W-1:0] idx_q;
   logic [1:0] ph_q;
   logic [`FSQ_TMR_W-1:0] tmr_q;
   logic is_wr_cmd, reg_wr_any, addr_bad, start, start_ok, start_bad, abort, fin;
   logic [`FSQ_ADDR_W-1:0] page_addr;

   fsq_buf_if #(.AW(`FSQ_IDX_W), .DW(`FSQ_DATA_W)) buf_if ();

   fsq_buf_ram #(.AW(`FSQ_IDX_W), .DW(`FSQ_DATA_W)) u_buf (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .port(buf_if.mem)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign is_wr_cmd = (cmd_q == `FSQ_CMD_WR_WORD) || (cmd_q == `FSQ_CMD_WR_INC) ||
                      (cmd_q == `FSQ_CMD_WR_PAGE) || (cmd_q == `FSQ_CMD_ER_PAGE);
   assign reg_wr_any = cmd_wr_in || addr_wr_in || data_wr_in || buf_wr_in;
   assign addr_bad = protect_in || (32'(addr_q) >= FLASH_BYTES); // see [RULE_02] see [RULE_03]
   assign start = ce_in && go_set_in && !go_q && (cmd_q != `FSQ_CMD_RSVD) && // see [RULE_22]
                  (!is_wr_cmd || (lock_q == fsq_pkg::FSQ_LOCK_ARMED && !lock_wr_in &&
                  !reg_wr_any)); // see [RULE_20] see [RULE_23]
   assign start_bad = start && is_wr_cmd && addr_bad; // see [RULE_08]
   assign start_ok = start && !start_bad;
   assign abort = ce_in && fault_rst_in && go_q && halt_q; // see [RULE_01]
   assign fin = ce_in && !abort && (
                ((state_q == fsq_pkg::FSQ_ST_RD_WORD) && (ph_q == `FSQ_PH_TAKE)) ||
                ((state_q == fsq_pkg::FSQ_ST_RD_PAGE) && (ph_q == `FSQ_PH_TAKE) &&
                 (idx_q == `FSQ_IDX_LAST)) ||
                ((state_q == fsq_pkg::FSQ_ST_PROG) && (tmr_q == `FSQ_TMR_ZERO)));
   assign page_addr = {addr_q[`FSQ_ADDR_W-1:`FSQ_PAGE_LSB], idx_q, `FSQ_BYTE_PAD}; // see [RULE_15]

   // ----------------------------------------
   // buffer port sharing
   // ----------------------------------------
   always_comb begin
      buf_if.en = ce_in;
      buf_if.addr = go_q ? idx_q : buf_addr_in;
      buf_if.wdata = go_q ? fl_rdata_in : buf_wdata_in;
      buf_if.we = go_q ? (state_q == fsq_pkg::FSQ_ST_RD_PAGE && ph_q == `FSQ_PH_TAKE && !abort)
                       : buf_wr_in; // see [RULE_04] see [RULE_11]
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= fsq_pkg::FSQ_ST_IDLE;
         idx_q <= `FSQ_RST_IDX;
         ph_q <= `FSQ_PH_ISSUE;
         tmr_q <= `FSQ_TMR_ZERO;
         fl_addr_q <= `FSQ_RST_ADDR;
         fl_wdata_q <= `FSQ_RST_DATA;
         fl_rd_q <= 1'b0;
         fl_wr_q <= 1'b0;
         fl_er_q <= 1'b0;
      end else if (ce_in) begin
         if (abort) begin
            state_q <= fsq_pkg::FSQ_ST_IDLE;
            fl_rd_q <= 1'b0;
            fl_wr_q <= 1'b0;
            fl_er_q <= 1'b0;
         end else begin
            unique case (state_q)
               fsq_pkg::FSQ_ST_IDLE: begin
                  idx_q <= `FSQ_RST_IDX;
                  ph_q <= `FSQ_PH_ISSUE;
                  if (start_ok) begin
                     unique case (cmd_q)
                        `FSQ_CMD_RD_WORD, `FSQ_CMD_RD_INC: state_q <= fsq_pkg::FSQ_ST_RD_WORD;
                        `FSQ_CMD_RD_PAGE: state_q <= fsq_pkg::FSQ_ST_RD_PAGE;
                        `FSQ_CMD_WR_WORD, `FSQ_CMD_WR_INC: state_q <= fsq_pkg::FSQ_ST_WR_WORD;
                        `FSQ_CMD_WR_PAGE: state_q <= fsq_pkg::FSQ_ST_WR_PAGE;
                        default: state_q <= fsq_pkg::FSQ_ST_ERASE;
                     endcase
                  end
               end
               fsq_pkg::FSQ_ST_RD_WORD, fsq_pkg::FSQ_ST_RD_PAGE: begin
                  fl_addr_q <= (state_q == fsq_pkg::FSQ_ST_RD_WORD) ? addr_q : page_addr;
                  fl_rd_q <= (ph_q == `FSQ_PH_ISSUE);
                  ph_q <= (ph_q == `FSQ_PH_TAKE) ? `FSQ_PH_ISSUE : ph_q + `FSQ_PH_STEP;
                  if (ph_q == `FSQ_PH_TAKE) begin
                     idx_q <= idx_q + `FSQ_IDX_STEP; // see [RULE_04] see [RULE_14]
                     if (fin) begin
                        state_q <= fsq_pkg::FSQ_ST_IDLE;
                     end
                  end
               end
               fsq_pkg::FSQ_ST_WR_WORD, fsq_pkg::FSQ_ST_ERASE: begin
                  fl_addr_q <= addr_q;
                  fl_wdata_q <= data_q; // see [RULE_19]
                  fl_wr_q <= (ph_q == `FSQ_PH_ISSUE) && (state_q == fsq_pkg::FSQ_ST_WR_WORD);
                  fl_er_q <= (ph_q == `FSQ_PH_ISSUE) && (state_q == fsq_pkg::FSQ_ST_ERASE);
                  ph_q <= `FSQ_PH_HOLD;
                  if (ph_q == `FSQ_PH_HOLD) begin
                     state_q <= fsq_pkg::FSQ_ST_PROG;
                     tmr_q <= `FSQ_TMR_W'(PROG_CYC - 1); // see [RULE_12]
                  end
               end
               fsq_pkg::FSQ_ST_WR_PAGE: begin
                  fl_wr_q <= (ph_q == `FSQ_PH_HOLD); // see [RULE_07]
                  ph_q <= (ph_q == `FSQ_PH_TAKE) ? `FSQ_PH_ISSUE : ph_q + `FSQ_PH_STEP;
                  if (ph_q == `FSQ_PH_HOLD) begin
                     fl_addr_q <= page_addr;
                     fl_wdata_q <= buf_if.rdata;
                  end
                  if (ph_q == `FSQ_PH_TAKE) begin
                     idx_q <= idx_q + `FSQ_IDX_STEP;
                     if (idx_q == `FSQ_IDX_LAST) begin
                        state_q <= fsq_pkg::FSQ_ST_PROG;
                        tmr_q <= `FSQ_TMR_W'(PROG_CYC - 1); // see [RULE_12]
                     end
                  end
               end
               fsq_pkg::FSQ_ST_PROG: begin
                  fl_wr_q <= 1'b0;
                  fl_er_q <= 1'b0;
                  tmr_q <= tmr_q - `FSQ_TMR_STEP;
                  if (fin) begin
                     state_q <= fsq_pkg::FSQ_ST_IDLE;
                  end
               end
               default: state_q <= fsq_pkg::FSQ_ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cmd_q <= `FSQ_CMD_RD_WORD;
         addr_q <= `FSQ_RST_ADDR;
         data_q <= `FSQ_RST_DATA;
      end else if (ce_in) begin
         if (!go_q && cmd_wr_in) begin
            cmd_q <= cmd_in; // see [RULE_21]
         end
         if (!go_q && addr_wr_in) begin
            addr_q <= addr_in; // see [RULE_21]
         end else if (fin && (cmd_q == `FSQ_CMD_RD_INC || cmd_q == `FSQ_CMD_WR_INC)) begin
            addr_q <= addr_q + `FSQ_ADDR_STEP;
         end
         if (state_q == fsq_pkg::FSQ_ST_RD_WORD && ph_q == `FSQ_PH_TAKE) begin
            data_q <= fl_rdata_in; // see [RULE_05]
         end else if (!go_q && data_wr_in) begin
            data_q <= data_in;
         end
      end
   end

   // ----------------------------------------
   // unlock tracking
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         lock_q <= fsq_pkg::FSQ_LOCK_NONE;
      end else if (ce_in) begin
         if (go_q || go_set_in || reg_wr_any) begin
            lock_q <= fsq_pkg::FSQ_LOCK_NONE; // see [RULE_23]
         end else if (lock_wr_in) begin
            if (lock_in == `FSQ_KEY_FIRST) begin
               lock_q <= fsq_pkg::FSQ_LOCK_FIRST;
            end else if (lock_q == fsq_pkg::FSQ_LOCK_FIRST && lock_in == `FSQ_KEY_SECOND) begin
               lock_q <= fsq_pkg::FSQ_LOCK_ARMED; // see [RULE_20]
            end else begin
               lock_q <= fsq_pkg::FSQ_LOCK_NONE;
            end
         end
      end
   end

   // ----------------------------------------
   // go, flags, halt
   // ----------------------------------------
   always_comb begin
      done_d = done_q;
      if (fin) begin
         done_d = 1'b1; // see [RULE_10]
      end else if (ce_in && done_clr_in && !go_q) begin
         done_d = 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         go_q <= 1'b0;
         err_q <= 1'b0;
         done_q <= 1'b0;
         irq_q <= 1'b0;
         halt_q <= 1'b0;
      end else if (ce_in) begin
         if (abort || fin) begin
            go_q <= 1'b0; // see [RULE_10]
         end else if (start_ok) begin
            go_q <= 1'b1;
         end
         if (start_bad || abort) begin
            err_q <= 1'b1; // see [RULE_01] see [RULE_08]
         end else if (err_clr_in && !go_q) begin
            err_q <= 1'b0;
         end
         done_q <= done_d;
         irq_q <= done_d && irq_en_in; // see [RULE_10]
         if (abort || fin) begin
            halt_q <= 1'b0;
         end else if (start_ok && is_wr_cmd) begin
            halt_q <= 1'b1; // see [RULE_09]
         end
      end
   end

   assign buf_rdata_out = buf_if.rdata;
   assign fl_addr_out = fl_addr_q;
   assign fl_rd_out = fl_rd_q;
   assign fl_wr_out = fl_wr_q;
   assign fl_erase_out = fl_er_q;
   assign fl_wdata_out = fl_wdata_q;
   assign go_out = go_q;
   assign cmd_out = cmd_q;
   assign addr_out = addr_q;
   assign data_out = data_q;
   assign err_out = err_q;
   assign done_out = done_q;
   assign irq_out = irq_q;
   assign cpu_halt_out = halt_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_KEYS_BEFORE_GO: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_23]
      $rose(go_q) && $past(is_wr_cmd) |-> $past(lock_q) == fsq_pkg::FSQ_LOCK_ARMED)
      else $error("write started without unlock");
   AST_BAD_ADDR_ERR: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_08]
      start_bad |=> err_q && !go_q && !fl_wr_q && !fl_er_q)
      else $error("bad address did not flag error");
   AST_RSVD_NOP: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_22]
      go_set_in && !go_q && cmd_q == `FSQ_CMD_RSVD |=> !go_q && !$rose(err_q) && !$rose(irq_q))
      else $error("reserved command acted");
   AST_ABORT_ERR: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_01]
      abort |=> err_q && !go_q && !halt_q)
      else $error("aborted write left no error");
   AST_HALT_PROG: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_09]
      state_q == fsq_pkg::FSQ_ST_PROG |-> halt_q && go_q)
      else $error("cpu not halted while programming");
   AST_DONE_IRQ: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_10]
      fin |=> done_q && !go_q && irq_q == $past(irq_en_in))
      else $error("completion flags wrong");
   AST_TIMER_LOAD: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_12]
      $rose(state_q == fsq_pkg::FSQ_ST_PROG) |-> tmr_q == `FSQ_TMR_W'(PROG_CYC - 1))
      else $error("programming timer not loaded");
   AST_PAGE_MAP: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_15]
      $rose(fl_wr_q) && state_q == fsq_pkg::FSQ_ST_WR_PAGE |->
      fl_addr_q[`FSQ_PAGE_LSB-1:1] == idx_q && fl_wdata_q == buf_if.rdata)
      else $error("page offset mismatch");
   AST_BUF_FROZEN: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_11]
      go_q && halt_q |-> !buf_if.we && $stable(cmd_q))
      else $error("buffer or command changed during write");
   AST_WORD_READ: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_05]
      ce_in && state_q == fsq_pkg::FSQ_ST_RD_WORD && ph_q == `FSQ_PH_TAKE |=>
      data_q == $past(fl_rdata_in))
      else $error("word read not captured");
   AST_REG_LOCKED: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_21]
      ce_in && go_q && cmd_wr_in && !abort && !fin |=> go_q && cmd_q == $past(cmd_q))
      else $error("register write while busy");
endmodule

`default_nettype wire

/* testbench/fsq_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// flash array and read port model
// ----------------------------------------
module fsq_flash_model (
   input wire logic clock_in,
   input wire logic [21:0] addr_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic erase_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out
);
   logic [15:0] mem [0:32767];
   logic [1:0] hold_q;

   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 16'hffff;
      end
      hold_q = 2'h0;
      rdata_out = 16'h0000;
   end

   always @(posedge clock_in) begin
      if (erase_in) begin
         for (int i = 0; i < 128; i++) begin
            mem[{addr_in[15:8], i[6:0]}] = 16'hffff;
         end
      end
      if (wr_in) begin
         mem[addr_in[15:1]] = mem[addr_in[15:1]] & wdata_in;
      end
      // read data holds three cycles, then the lines churn
      if (rd_in) begin
         rdata_out <= mem[addr_in[15:1]];
         hold_q <= 2'h2;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end else begin
         rdata_out <= ~rdata_out;
      end
   end
endmodule

`default_nettype wire

/* testbench/test_program_flash_page_word_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module test_program_flash_page_word_sequencer;
   localparam int PROG = 4;
   logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, cmd_wr_in = 1'b0, addr_wr_in = 1'b0;
   logic data_wr_in = 1'b0, lock_wr_in = 1'b0, go_set_in = 1'b0, irq_en_in = 1'b1;
   logic done_clr_in = 1'b0, err_clr_in = 1'b0, protect_in = 1'b0, fault_rst_in = 1'b0;
   logic buf_wr_in = 1'b0;
   logic [2:0] cmd_in = 3'h0;
   logic [21:0] addr_in = 22'h00_0000;
   logic [15:0] data_in = 16'h0000, buf_wdata_in = 16'h0000, fl_rdata_in;
   logic [7:0] lock_in = 8'h00;
   logic [6:0] buf_addr_in = 7'h00;
   logic [15:0] buf_rdata_out, fl_wdata_out, data_out, d;
   logic [21:0] fl_addr_out, addr_out, a, p;
   logic fl_rd_out, fl_wr_out, fl_erase_out, go_out, err_out, done_out, irq_out, cpu_halt_out;
   logic [2:0] cmd_out;
   int n_fail = 0, n_checks = 0, cyc;
   integer seed = 32'h16db_aaa0;
   int fm [int];
   int bm [128];

   fsq_sequencer #(.PROG_CYC(PROG)) dut (.clock_in, .rst_in, .ce_in, .cmd_wr_in, .cmd_in,
      .addr_wr_in, .addr_in, .data_wr_in, .data_in, .lock_wr_in, .lock_in, .go_set_in,
      .irq_en_in, .done_clr_in, .err_clr_in, .protect_in, .fault_rst_in, .buf_wr_in,
      .buf_addr_in, .buf_wdata_in, .buf_rdata_out, .fl_rdata_in, .fl_addr_out, .fl_rd_out,
      .fl_wr_out, .fl_erase_out, .fl_wdata_out, .go_out, .cmd_out, .addr_out, .data_out,
      .err_out, .done_out, .irq_out, .cpu_halt_out);
   fsq_flash_model flash (.clock_in, .addr_in(fl_addr_out), .rd_in(fl_rd_out),
      .wr_in(fl_wr_out), .erase_in(fl_erase_out), .wdata_in(fl_wdata_out),
      .rdata_out(fl_rdata_in));

   always #2.5 clock_in = ~clock_in;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic int fget(input int i);
      return fm.exists(i) ? fm[i] : 32'h0000_ffff;
   endfunction

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clock_in);
      s = 1'b0;
   endtask

   task automatic set_cmd(input logic [2:0] c);
      cmd_in = c;
      pulse(cmd_wr_in);
   endtask

   task automatic set_addr(input logic [21:0] v);
      addr_in = v;
      pulse(addr_wr_in);
   endtask

   task automatic unlock();
      lock_wr_in = 1'b1; // keys back to back
      lock_in = 8'h55;
      @(negedge clock_in);
      lock_in = 8'haa;
      @(negedge clock_in);
      lock_wr_in = 1'b0;
   endtask

   task automatic wait_done();
      cyc = 0;
      while (go_out === 1'b1 && cyc < 2000) begin
         cyc++;
         @(negedge clock_in);
      end
      if (cyc >= 2000) begin
         n_fail++;
      end
      @(negedge clock_in);
   endtask

   task automatic fill(input bit inv);
      buf_wr_in = 1'b1;
      for (int i = 0; i < 128; i++) begin
         buf_addr_in = i[6:0];
         buf_wdata_in = inv ? ~bm[i][15:0] : bm[i][15:0];
         @(negedge clock_in);
      end
      buf_wr_in = 1'b0;
   endtask

   task automatic buf_chk(input int i, input int e);
      buf_addr_in = i[6:0];
      @(negedge clock_in);
      chk(buf_rdata_out, e[15:0]);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge clock_in);
      rst_in = 1'b0;
      chk({go_out, err_out, done_out, cpu_halt_out}, 4'h0);
      a = 22'($random(seed)) & 22'h00_7ffe;
      d = 16'($random(seed));
      set_addr(a); // target is still erased
      data_in = d;
      pulse(data_wr_in);
      set_cmd(3'h3);
      unlock();
      pulse(go_set_in);
      chk(cpu_halt_out, 1'b1);
      wait_done();
      chk(cyc >= PROG, 1'b1);
      chk({done_out, irq_out, cpu_halt_out}, 3'h6);
      fm[a >> 1] = d;
      for (int k = 0; k < 2; k++) begin
         pulse(done_clr_in);
         set_addr(a);
         set_cmd(3'(k));
         pulse(go_set_in);
         wait_done();
         chk(data_out, fget(a >> 1));
      end
      chk(addr_out, a + 22'h00_0002);
      set_cmd(3'h3);
      pulse(go_set_in);
      chk(go_out, 1'b0);
      unlock();
      pulse(data_wr_in);
      pulse(go_set_in);
      chk(go_out, 1'b0);
      set_cmd(3'h5);
      protect_in = 1'b1;
      unlock();
      pulse(go_set_in);
      chk({go_out, err_out}, 2'h1);
      protect_in = 1'b0;
      pulse(err_clr_in);
      chk(err_out, 1'b0);
      set_addr(22'h01_0000);
      set_cmd(3'h6);
      unlock();
      pulse(go_set_in);
      chk({go_out, err_out}, 2'h1);
      pulse(err_clr_in);
      pulse(done_clr_in);
      set_cmd(3'h7);
      pulse(go_set_in);
      @(negedge clock_in);
      chk({go_out, err_out, done_out, irq_out}, 4'h0);
      p = {7'h00, 7'($random(seed)), 8'h00};
      for (int i = 0; i < 128; i++) begin
         bm[i] = $random(seed) & 32'h0000_ffff;
      end
      fill(1'b0);
      set_addr(p | 22'h00_0036); // erase, then page write
      set_cmd(3'h6);
      unlock();
      pulse(go_set_in);
      wait_done();
      chk(err_out, 1'b0);
      set_cmd(3'h5);
      unlock();
      pulse(go_set_in);
      chk(cpu_halt_out, 1'b1);
      set_cmd(3'h0);
      set_addr(22'h00_0000);
      buf_addr_in = 7'h05;
      buf_wdata_in = ~bm[5][15:0];
      pulse(buf_wr_in);
      chk(go_out, 1'b1);
      wait_done();
      chk({cmd_out, addr_out}, {3'h5, p | 22'h00_0036});
      buf_chk(5, bm[5]);
      for (int i = 0; i < 128; i++) begin
         fm[(p >> 1) + i] = bm[i];
      end
      fill(1'b1);
      set_cmd(3'h2);
      pulse(go_set_in);
      wait_done();
      for (int i = 0; i < 128; i++) begin
         buf_chk(i, fget((p >> 1) + i));
      end
      pulse(done_clr_in);
      set_cmd(3'h3);
      unlock();
      pulse(go_set_in);
      pulse(fault_rst_in);
      chk({go_out, err_out, done_out, cpu_halt_out}, 4'h4);
      irq_en_in = 1'b0;
      pulse(err_clr_in);
      set_addr(22'h00_fffe);
      set_cmd(3'h4);
      unlock();
      pulse(go_set_in);
      wait_done();
      chk({done_out, irq_out, err_out}, 3'h4);
      chk(addr_out, 22'h01_0000);
      fm[32'h0000_7fff] = d;
      set_addr(22'h00_fffe);
      set_cmd(3'h0);
      pulse(go_set_in);
      wait_done();
      chk(data_out, fget(32'h0000_7fff));
      complete_run();
   end

   initial begin
      #100_000;
      n_fail++;
      complete_run();
   end
endmodule

`default_nettype wire
